// ===== inc/pcr_defines.svh
// offsets, field positions, reset values and timing counts of the rate-adjust block
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

// register indices; the byte address is four times the index
`define PCR_IDX_CTRL      16'h0500
`define PCR_IDX_SEC_LO    16'h050a
`define PCR_IDX_RATE_HI   16'h050c
`define PCR_IDX_RATE_LO   16'h050e
`define PCR_IDX_DUR_HI    16'h0510
`define PCR_IDX_DUR_LO    16'h0512

// clock control field positions
`define PCR_CTRL_READ     4
`define PCR_CTRL_LOAD     3
`define PCR_CTRL_CONT     2
`define PCR_CTRL_EN       1
`define PCR_CTRL_RST      0

// rate high word field positions
`define PCR_RATE_DIR      15
`define PCR_RATE_TEMP     14
`define PCR_RATE_HI_MSB   13

// reset values
`define PCR_RST_WORD      16'h0000
`define PCR_RST_DUR       32'h0000_0000
`define PCR_RST_BIT       1'b0

// timing: system clock period and adjustment tick period, in ns
`define PCR_CLK_PERIOD_NS   5
`define PCR_TICK_PERIOD_NS  40
`define PCR_TICK_DIV        (`PCR_TICK_PERIOD_NS / `PCR_CLK_PERIOD_NS)

`endif

// ===== inc/pcr_pkg.sv
// types shared by the rate-adjust block
package pcr_pkg;

    // temporary adjustment sequencer states
    typedef enum logic [0:0] {
        PCR_TMP_IDLE,
        PCR_TMP_RUN
    } pcr_temp_e;

    // register selected by an apb address
    typedef enum logic [2:0] {
        PCR_SEL_NONE,
        PCR_SEL_CTRL,
        PCR_SEL_SEC_LO,
        PCR_SEL_RATE_HI,
        PCR_SEL_RATE_LO,
        PCR_SEL_DUR_HI,
        PCR_SEL_DUR_LO
    } pcr_sel_e;

endpackage

// ===== core/pcr_tick_gen.sv
// divider making the one-cycle 25 mhz adjustment tick from pclk
`timescale 1ns/1ps
module pcr_tick_gen #(
    parameter int DIV = 8
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // tick enable
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;

    // refuse a divider that cannot make a tick
    initial begin
        if (DIV < 1) begin
            $error("tick divider must be at least one");
        end
    end

    // free-running count, tick registered at the last count, so it is high in the first cycle of each period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == LAST) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + CW'(1);
            tick  <= 1'b0;
        end
    end
endmodule

// ===== core/pcr_clock_rate_adjust.sv
// apb register block steering rate adjustment of the precision clock
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pcr_defines.svh"

// Notes on behaviour
// - seconds low word, read/write, resets zero
// - direction one adds rate each tick
// - direction zero subtracts rate each tick
// - temporary bit adjusts for duration ticks
// - writing zero halts temporary adjustment
// - rate high word holds rate bits 29:16
// - low word holds rate 15:0, both modes
// - duration is 32-bit, high word 31:16
// - duration low word read/write, resets zero
// - continuous mode adjusts every tick, unlimited
// - clock read bit captures current time
// - clock load bit loads held time
// - clock reset bit resets clock time
module pcr_clock_rate_adjust
    import pcr_pkg::*;
#(
    parameter int RATE_W   = 30,
    parameter int DUR_W    = 32,
    parameter int TICK_DIV = `PCR_TICK_DIV
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [15:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // time core: live seconds and command strobes
    input  wire logic [15:0]       rtc_seconds_now,
    output logic      [15:0]       rtc_seconds_low,
    output logic                   clock_enable,
    output logic                   clock_reset_pulse,
    output logic                   clock_read_pulse,
    output logic                   clock_load_pulse,
    // time core: rate step
    output logic                   adjust_pulse,
    output logic                   adjust_add,
    output logic      [RATE_W-1:0] adjust_rate,
    output logic                   temp_adjust_busy
);

    // refuse widths the split word registers cannot hold
    initial begin
        if (RATE_W != 30) begin
            $error("rate width must be 30");
        end
        if (DUR_W != 32) begin
            $error("duration width must be 32");
        end
        if (TICK_DIV < 1) begin
            $error("tick divider must be at least one");
        end
    end

    // map a byte address to a register; only aligned words hit
    function automatic pcr_sel_e decode(input logic [15:0] addr);
        pcr_sel_e sel;
        logic [15:0] idx;
        sel = PCR_SEL_NONE;
        idx = {2'b00, addr[15:2]}; // word index, as wide as the index constants
        if (addr[1:0] == 2'h0) begin
            case (idx)
                `PCR_IDX_CTRL:    sel = PCR_SEL_CTRL;
                `PCR_IDX_SEC_LO:  sel = PCR_SEL_SEC_LO;
                `PCR_IDX_RATE_HI: sel = PCR_SEL_RATE_HI;
                `PCR_IDX_RATE_LO: sel = PCR_SEL_RATE_LO;
                `PCR_IDX_DUR_HI:  sel = PCR_SEL_DUR_HI;
                `PCR_IDX_DUR_LO:  sel = PCR_SEL_DUR_LO;
                default:          sel = PCR_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // byte-lane merge of a write into a 16-bit word
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] wdat,
        input logic [1:0]  strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res;
    endfunction

    // software-held state
    logic              rate_dir;
    logic [13:0]       rate_hi;
    logic [15:0]       rate_lo;
    logic [15:0]       dur_hi;
    logic [15:0]       dur_lo;
    logic              cont_adjust;

    // temporary adjustment sequencer
    pcr_temp_e         temp_state;
    pcr_temp_e         next_temp_state;
    logic [DUR_W-1:0]  temp_left;
    logic [DUR_W-1:0]  next_temp_left;

    // bus decode
    pcr_sel_e          rd_sel;
    pcr_sel_e          wr_sel;
    logic              wr_en;
    logic [15:0]       wdat;
    logic [1:0]        wstrb;
    logic [15:0]       rd_word;
    logic [15:0]       rate_hi_word;
    logic [15:0]       ctrl_word;
    logic              tick;
    logic              temp_start;
    logic              temp_stop;
    logic              temp_active;
    logic [DUR_W-1:0]  dur_full;
    logic [15:0]       rate_hi_merged;

    // 25 mhz adjustment tick
    pcr_tick_gen #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // write strobe at the access edge of a granted transfer
    assign wr_en  = psel & penable & pready & pwrite;
    assign wr_sel = decode(paddr);
    assign rd_sel = decode(paddr);
    assign wdat   = pwdata[15:0];
    assign wstrb  = pstrb[1:0];
    assign dur_full = {dur_hi, dur_lo};

    // high word after byte-lane merge, sliced below into the rate field
    assign rate_hi_merged = merge(rate_hi_word, wdat, wstrb);

    // readback words; strobe bits read as zero
    assign temp_active  = (temp_state == PCR_TMP_RUN);
    assign rate_hi_word = {rate_dir, temp_active, rate_hi};
    assign ctrl_word    = {11'h000, 1'b0, 1'b0, cont_adjust, clock_enable, 1'b0};

    // read multiplexer
    always_comb begin
        rd_word = 16'h0000;
        case (rd_sel)
            PCR_SEL_CTRL:    rd_word = ctrl_word;
            PCR_SEL_SEC_LO:  rd_word = rtc_seconds_low;
            PCR_SEL_RATE_HI: rd_word = rate_hi_word;
            PCR_SEL_RATE_LO: rd_word = rate_lo;
            PCR_SEL_DUR_HI:  rd_word = dur_hi;
            PCR_SEL_DUR_LO:  rd_word = dur_lo;
            default:         rd_word = 16'h0000;
        endcase
    end

    // apb answer: one wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                pslverr <= (rd_sel == PCR_SEL_NONE);
                prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
            end
        end
    end

    // rate word and direction storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_dir <= `PCR_RST_BIT;
            rate_hi  <= 14'h0000;
            rate_lo  <= `PCR_RST_WORD;
        end else if (wr_en) begin
            if (wr_sel == PCR_SEL_RATE_HI) begin
                rate_hi  <= rate_hi_merged[`PCR_RATE_HI_MSB:0];
                if (wstrb[1]) begin
                    rate_dir <= wdat[`PCR_RATE_DIR];
                end
            end
            if (wr_sel == PCR_SEL_RATE_LO) begin
                rate_lo <= merge(rate_lo, wdat, wstrb);
            end
        end
    end

    // duration words; the running count keeps its own copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dur_hi <= `PCR_RST_WORD;
            dur_lo <= `PCR_RST_WORD;
        end else if (wr_en) begin
            if (wr_sel == PCR_SEL_DUR_HI) begin
                dur_hi <= merge(dur_hi, wdat, wstrb);
            end
            if (wr_sel == PCR_SEL_DUR_LO) begin
                dur_lo <= merge(dur_lo, wdat, wstrb);
            end
        end
    end

    // seconds low word: software write or capture on clock read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_seconds_low <= `PCR_RST_WORD;
        end else if (wr_en && wr_sel == PCR_SEL_CTRL && wstrb[0]
                     && wdat[`PCR_CTRL_READ]) begin
            rtc_seconds_low <= rtc_seconds_now;
        end else if (wr_en && wr_sel == PCR_SEL_SEC_LO) begin
            rtc_seconds_low <= merge(rtc_seconds_low, wdat, wstrb);
        end
    end

    // clock control levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cont_adjust  <= `PCR_RST_BIT;
            clock_enable <= `PCR_RST_BIT;
        end else if (wr_en && wr_sel == PCR_SEL_CTRL && wstrb[0]) begin
            cont_adjust  <= wdat[`PCR_CTRL_CONT];
            clock_enable <= wdat[`PCR_CTRL_EN];
        end
    end

    // self-clearing commands become one-cycle strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_reset_pulse <= 1'b0;
            clock_read_pulse  <= 1'b0;
            clock_load_pulse  <= 1'b0;
        end else begin
            clock_reset_pulse <= 1'b0;
            clock_read_pulse  <= 1'b0;
            clock_load_pulse  <= 1'b0;
            if (wr_en && wr_sel == PCR_SEL_CTRL && wstrb[0]) begin
                clock_reset_pulse <= wdat[`PCR_CTRL_RST];
                clock_read_pulse  <= wdat[`PCR_CTRL_READ];
                clock_load_pulse  <= wdat[`PCR_CTRL_LOAD];
            end
        end
    end

    // software start and stop of a temporary run
    assign temp_start = wr_en && wr_sel == PCR_SEL_RATE_HI && wstrb[1]
                        && wdat[`PCR_RATE_TEMP];
    assign temp_stop  = wr_en && wr_sel == PCR_SEL_RATE_HI && wstrb[1]
                        && !wdat[`PCR_RATE_TEMP];

    // temporary sequencer: a software write wins over expiry
    // the running count is a private copy, so duration rewrites wait for the next start
    always_comb begin
        next_temp_state = temp_state;
        next_temp_left  = temp_left;
        case (temp_state)
            PCR_TMP_IDLE: begin
                if (temp_start && dur_full != '0) begin
                    next_temp_state = PCR_TMP_RUN;
                    next_temp_left  = dur_full;
                end
            end
            PCR_TMP_RUN: begin
                if (temp_stop) begin
                    next_temp_state = PCR_TMP_IDLE;
                    next_temp_left  = '0;
                end else if (tick) begin
                    next_temp_left = temp_left - DUR_W'(1);
                    if (temp_left == DUR_W'(1)) begin
                        next_temp_state = PCR_TMP_IDLE;
                        // a start written at the expiry edge wins over the hardware clear
                        if (temp_start && dur_full != '0) begin
                            next_temp_state = PCR_TMP_RUN;
                            next_temp_left  = dur_full;
                        end
                    end
                end
            end
            default: begin
                next_temp_state = PCR_TMP_IDLE;
                next_temp_left  = '0;
            end
        endcase
    end

    // temporary sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_state <= PCR_TMP_IDLE;
            temp_left  <= `PCR_RST_DUR;
        end else begin
            temp_state <= next_temp_state;
            temp_left  <= next_temp_left;
        end
    end

    // busy flag mirrors the sequencer for the time core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_adjust_busy <= 1'b0;
        end else begin
            temp_adjust_busy <= (next_temp_state == PCR_TMP_RUN);
        end
    end

    // rate step toward the time core, once per tick while a mode runs
    // rate and direction are latched at the tick so a mid-period write cannot tear a step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adjust_pulse <= 1'b0;
            adjust_add   <= 1'b0;
            adjust_rate  <= '0;
        end else begin
            adjust_pulse <= tick && (cont_adjust || temp_active);
            if (tick) begin
                adjust_add  <= rate_dir;
                adjust_rate <= {rate_hi, rate_lo};
            end
        end
    end

endmodule

// ===== dv/pcr_chk.sv
// concurrent checks on the apb answer and time-core strobes of the rate block
`timescale 1ns/1ps
module pcr_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // time core
    input wire logic [15:0] rtc_seconds_now,
    input wire logic [15:0] rtc_seconds_low,
    input wire logic        clock_reset_pulse,
    input wire logic        clock_read_pulse,
    input wire logic        clock_load_pulse,
    input wire logic        adjust_pulse,
    input wire logic        adjust_add,
    input wire logic        temp_adjust_busy
);
    // committed control write with the low byte enabled
    wire ctl_wr = psel && penable && pready && pwrite && paddr == 16'h1400 && pstrb[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_lat; psel && !penable |=> pready; endproperty
    property p_rdy_one; pready |=> !pready; endproperty
    property p_err_bad; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
    property p_rd_cmd; ctl_wr && pwdata[4] |=> clock_read_pulse; endproperty
    property p_ld_cmd; ctl_wr && pwdata[3] |=> clock_load_pulse; endproperty
    property p_rs_cmd; ctl_wr && pwdata[0] |=> clock_reset_pulse; endproperty
    property p_no_cmd;
        !ctl_wr |=> !clock_read_pulse && !clock_load_pulse && !clock_reset_pulse;
    endproperty
    property p_sec_cap; clock_read_pulse |-> rtc_seconds_low == $past(rtc_seconds_now); endproperty
    property p_adj_gap; adjust_pulse |=> (!adjust_pulse) [*7]; endproperty
    a_rdy_lat:
        assert property (p_rdy_lat) else $error("no answer one cycle after setup");
    a_rdy_one:
        assert property (p_rdy_one) else $error("answer longer than one cycle");
    a_err_bad:
        assert property (p_err_bad) else $error("misaligned access not refused");
    a_wr_zero:
        assert property (p_wr_zero) else $error("read data not zero on write");
    a_rd_cmd:
        assert property (p_rd_cmd) else $error("clock read strobe missing");
    a_ld_cmd:
        assert property (p_ld_cmd) else $error("clock load strobe missing");
    a_rs_cmd:
        assert property (p_rs_cmd) else $error("clock reset strobe missing");
    a_no_cmd:
        assert property (p_no_cmd) else $error("strobe without control write");
    a_sec_cap:
        assert property (p_sec_cap) else $error("seconds not captured");
    a_adj_gap:
        assert property (p_adj_gap) else $error("adjust steps closer than a tick");
    // main scenarios
    cover property (adjust_pulse && adjust_add);
    cover property (adjust_pulse && !adjust_add);
    cover property ($fell(temp_adjust_busy));
    cover property (pready && pslverr);
endmodule
bind pcr_clock_rate_adjust pcr_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rtc_seconds_now(rtc_seconds_now),
    .rtc_seconds_low(rtc_seconds_low), .clock_reset_pulse(clock_reset_pulse),
    .clock_read_pulse(clock_read_pulse), .clock_load_pulse(clock_load_pulse),
    .adjust_pulse(adjust_pulse), .adjust_add(adjust_add), .temp_adjust_busy(temp_adjust_busy));

// ===== dv/testbench.sv
// self-checking bench for the rate-adjust register block
`timescale 1ns/1ps
module testbench;
    // apb master and live seconds
    logic        pclk, presetn, psel, penable, pwrite;
    logic [15:0] paddr, rtc_seconds_now, rtc_seconds_low;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic        pready, pslverr, clock_enable, clock_reset_pulse, clock_read_pulse, e;
    logic        clock_load_pulse, adjust_pulse, adjust_add, temp_adjust_busy;
    logic [29:0] adjust_rate;
    int          n_mismatch, total_checks, n_pulse, c0;
    // byte addresses
    localparam logic [15:0] A_CTL = 16'h1400, A_SEC = 16'h1428, A_RHI = 16'h1430;
    localparam logic [15:0] A_RLO = 16'h1438, A_DHI = 16'h1440, A_DLO = 16'h1448;

    pcr_clock_rate_adjust dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rtc_seconds_now(rtc_seconds_now),
        .rtc_seconds_low(rtc_seconds_low), .clock_enable(clock_enable),
        .clock_reset_pulse(clock_reset_pulse), .clock_read_pulse(clock_read_pulse),
        .clock_load_pulse(clock_load_pulse), .adjust_pulse(adjust_pulse),
        .adjust_add(adjust_add), .adjust_rate(adjust_rate),
        .temp_adjust_busy(temp_adjust_busy));

    // compares and counts
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(32'(pready), 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // counts adjustment steps
    always @(posedge pclk) begin
        if (adjust_pulse === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
    end
    // clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // watchdog
    initial begin
        idle(20000);
        n_mismatch++;
        results();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        rtc_seconds_now = 16'h7e11;
        n_pulse = 0;
        idle(8);
        presetn <= 1'b1;
        rd(A_SEC, 32'h0);
        rd(A_RHI, 32'h0);
        rd(A_RLO, 32'h0);
        rd(A_DHI, 32'h0);
        rd(A_DLO, 32'h0);
        apb(1'b1, A_SEC, 32'hffff_a5c3);
        rd(A_SEC, 32'h0000_a5c3);
        chk(32'(rtc_seconds_low), 32'ha5c3);
        // continuous adding, then subtracting, with the full rate
        apb(1'b1, A_RLO, 32'h1234);
        apb(1'b1, A_RHI, 32'haabc);
        rd(A_RHI, 32'haabc);
        apb(1'b1, A_CTL, 32'h4);
        idle(20);
        chk(32'(adjust_add), 32'h1);
        chk(32'(adjust_rate), 32'h2abc_1234);
        c0 = n_pulse;
        idle(80);
        chk(32'(n_pulse - c0), 32'd10);
        apb(1'b1, A_RHI, 32'h2abc);
        idle(20);
        chk(32'(adjust_add), 32'h0);
        apb(1'b1, A_CTL, 32'h0);
        // temporary run of three ticks, then self clear
        apb(1'b1, A_DLO, 32'h3);
        idle(4);
        c0 = n_pulse;
        apb(1'b1, A_RHI, 32'h6abc);
        rd(A_RHI, 32'h6abc);
        idle(60);
        chk(32'(n_pulse - c0), 32'd3);
        rd(A_RHI, 32'h2abc);
        chk(32'(temp_adjust_busy), 32'h0);
        // zero duration starts nothing
        apb(1'b1, A_DLO, 32'h0);
        apb(1'b1, A_RHI, 32'h6abc);
        rd(A_RHI, 32'h2abc);
        // long run from the high word, rewrite, then halt
        apb(1'b1, A_DHI, 32'h1);
        apb(1'b1, A_RHI, 32'h6abc);
        idle(40);
        chk(32'(temp_adjust_busy), 32'h1);
        apb(1'b1, A_DHI, 32'h0);
        idle(40);
        chk(32'(temp_adjust_busy), 32'h1);
        apb(1'b1, A_RHI, 32'h2abc);
        idle(4);
        c0 = n_pulse;
        idle(40);
        chk(32'(n_pulse - c0), 32'd0);
        chk(32'(temp_adjust_busy), 32'h0);
        // strobes with capture of live seconds
        apb(1'b1, A_CTL, 32'h1b);
        idle(1);
        chk(32'(clock_read_pulse), 32'h1);
        chk(32'(clock_load_pulse), 32'h1);
        chk(32'(clock_reset_pulse), 32'h1);
        idle(1);
        chk(32'(clock_load_pulse), 32'h0);
        chk(32'(rtc_seconds_low), 32'h7e11);
        rd(A_CTL, 32'h2);
        chk(32'(clock_enable), 32'h1);
        // unmapped and misaligned places
        apb(1'b0, 16'h1404, 32'h0);
        chk(32'(e), 32'h1);
        chk(q, 32'h0);
        apb(1'b0, 16'h1429, 32'h0);
        chk(32'(e), 32'h1);
        results();
    end
endmodule
